// ==== verilog/ccp_pwm_pkg.sv ====
// Shared constants and types of the capture/compare/PWM support block
package ccp_pwm_pkg;
	localparam int INSTANCE_COUNT = 4;
	localparam int UNIT_COUNT = 4;
	localparam int CHANNEL_COUNT = 8;

	// Register byte addresses, each register one aligned word
	localparam logic [7:0] ADDR_CCP_ASSIGN = 8'h00;
	localparam logic [7:0] ADDR_PWM_SELECT = 8'h04;
	localparam logic [7:0] ADDR_INST_BASE = 8'h10;
	localparam logic [7:0] INST_STRIDE = 8'h10;
	localparam logic [7:0] INST_CTRL_OFS = 8'h00;
	localparam logic [7:0] INST_LOW_OFS = 8'h04;
	localparam logic [7:0] INST_HIGH_OFS = 8'h08;
	localparam logic [7:0] ADDR_UNIT_BASE = 8'h50;
	localparam logic [7:0] UNIT_STRIDE = 8'h08;
	localparam logic [7:0] UNIT_CTRL_OFS = 8'h00;
	localparam logic [7:0] UNIT_DUTY_OFS = 8'h04;
	localparam logic [7:0] ADDR_PERIOD = 8'h80;
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h84;
	localparam logic [7:0] ADDR_TIMER_COUNT = 8'h88;

	// Values after reset
	localparam logic [7:0] CCP_ASSIGN_RESET = 8'h00;
	localparam logic [7:0] PWM_SELECT_RESET = 8'h55;
	localparam logic [7:0] PERIOD_RESET = 8'hFF;
	localparam logic [4:0] TIMER_MODE_RESET = 5'h00;

	// Field positions
	localparam int UNIT_EN_BIT = 7;
	localparam int UNIT_OUT_BIT = 5;
	localparam int UNIT_POL_BIT = 4;
	localparam int INST_OUT_BIT = 7;
	localparam int INST_OD_BIT = 4;
	localparam int TIMER_RUN_BIT = 7;

	// Timer choice codes
	localparam logic [1:0] TSEL_SECOND = 2'b01;
	localparam logic [1:0] TSEL_THIRD = 2'b10;

	// Base timer level-reset one-shot modes
	localparam logic [4:0] MODE_LEVEL_LOW = 5'b01110;
	localparam logic [4:0] MODE_LEVEL_HIGH = 5'b01111;

	typedef enum logic [1:0] {CCP_OFF, CCP_CAPTURE, CCP_COMPARE, CCP_PWM} ccp_mode_type;
	typedef enum logic [1:0] {SHOT_IDLE, SHOT_ARMED, SHOT_COUNTING} shot_state_type;
endpackage

// ==== verilog/pwm_base_timer.sv ====
// Period timer feeding PWM, with level-reset edge-start one-shot modes
`timescale 1ns/1ps
module pwm_base_timer
	import ccp_pwm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Configuration
	input wire logic [4:0] timerMode,
	input wire logic [7:0] period,
	input wire logic runWrite,
	input wire logic runValue,
	// Synchronised external level
	input wire logic trigger,
	// Status
	output logic [7:0] count,
	output logic running,
	output logic oneShot,
	output logic startPulse
);
	shot_state_type state;
	logic trigPrev;
	logic resetLevel;
	logic atReset;
	logic leave;
	logic match;

	assign oneShot = (timerMode == MODE_LEVEL_LOW) || (timerMode == MODE_LEVEL_HIGH);
	assign resetLevel = (timerMode == MODE_LEVEL_HIGH);
	assign atReset = (trigger == resetLevel);
	assign leave = (trigPrev == resetLevel) && (trigger != resetLevel);
	assign match = (count == period);
	assign startPulse = oneShot && running && (state == SHOT_ARMED) && leave;

	always_ff @(posedge core_clk)
	begin
		if (srst)
			trigPrev <= 1'b0;
		else
			trigPrev <= trigger;
	end

	// Software write wins over the clear at period match
	always_ff @(posedge core_clk)
	begin
		if (srst)
			running <= 1'b0;
		else if (runWrite)
			running <= runValue;
		else if (oneShot && state == SHOT_COUNTING && !atReset && match)
			running <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst || !running || !oneShot)
			state <= SHOT_IDLE;
		else
		begin
			unique case (state)
				SHOT_IDLE: state <= SHOT_ARMED;
				SHOT_ARMED: if (leave) state <= SHOT_COUNTING;
				SHOT_COUNTING:
				begin
					if (atReset)
						state <= SHOT_ARMED;
					else if (match)
						state <= SHOT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			count <= 8'h00;
		else if (oneShot)
		begin
			if (state != SHOT_COUNTING || atReset || match)
				count <= 8'h00;
			else
				count <= count + 8'h01;
		end
		else if (running)
			count <= match ? 8'h00 : count + 8'h01;
	end
endmodule

// ==== verilog/ccp_pwm_timer_select.sv ====
// Four capture/compare/PWM instances, four PWM units and their timer routing
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Four identical instances, each choosing its timer
// - Reset choice is timer1 or timer2 by mode
// - Capture/compare use timers 1,3,5; PWM 2,4,6
// - All run together; shared timers allowed
// - Compare/PWM output may be open-drain
// - Data value split into low, high bytes
// - Unit select fields: 00,01,10 pick timers 2,4,6
// - Control bit 7 enables unit, resets 0
// - Control bit 5 reads output level only
// - Control bit 4 inverts unit output
// - Control bits 6 and 3-0 read zero
// - One-shot count held clear at reset level
// - Count starts on leaving edge while running
// - Period match clears count and run bit
// - Restart needs fresh edge after run set
// - One-shot PWM drive rises on start edge
// - Drive falls at pulse width, not at wrap
module ccp_pwm_timer_select
	import ccp_pwm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Avalon-MM register slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Counts of the on-chip timers
	input wire logic [15:0] timer1Count,
	input wire logic [15:0] timer3Count,
	input wire logic [15:0] timer5Count,
	input wire logic [7:0] timer4Count,
	input wire logic [7:0] timer6Count,
	// External pins
	input wire logic externalTrigger,
	input wire logic [ccp_pwm_pkg::INSTANCE_COUNT-1:0] captureIn,
	// Instance pin drivers, enable low while driving
	output logic [ccp_pwm_pkg::INSTANCE_COUNT-1:0] ccpPinOut,
	output logic [ccp_pwm_pkg::INSTANCE_COUNT-1:0] ccpPinOeN,
	// PWM unit outputs
	output logic [ccp_pwm_pkg::UNIT_COUNT-1:0] unitOut
);
	import ccp_pwm_pkg::*;

	function automatic logic [15:0] oddCount(input logic [1:0] sel, input logic [15:0] t1,
		input logic [15:0] t3, input logic [15:0] t5);
		if (sel == TSEL_SECOND)
			oddCount = t3;
		else if (sel == TSEL_THIRD)
			oddCount = t5;
		else
			oddCount = t1;
	endfunction

	function automatic logic [7:0] evenCount(input logic [1:0] sel, input logic [7:0] t2,
		input logic [7:0] t4, input logic [7:0] t6);
		if (sel == TSEL_SECOND)
			evenCount = t4;
		else if (sel == TSEL_THIRD)
			evenCount = t6;
		else
			evenCount = t2;
	endfunction

	function automatic logic onBaseTimer(input logic [1:0] sel);
		onBaseTimer = (sel != TSEL_SECOND) && (sel != TSEL_THIRD);
	endfunction

	logic ack;
	logic wrEn;
	logic [7:0] wData;
	logic [7:0] readByte;
	logic [7:0] ccpAssign;
	logic [7:0] pwmSelect;
	logic [7:0] periodReg;
	logic [4:0] timerMode;
	logic runWrite;
	logic [7:0] baseCount;
	logic running;
	logic oneShot;
	logic startPulse;
	logic trigSync1;
	logic trigSync2;
	logic [INSTANCE_COUNT-1:0] capSync1;
	logic [INSTANCE_COUNT-1:0] capSync2;
	logic [INSTANCE_COUNT-1:0] capPrev;
	ccp_mode_type instMode [INSTANCE_COUNT];
	logic [INSTANCE_COUNT-1:0] instOpenDrain;
	logic [15:0] instData [INSTANCE_COUNT];
	logic [INSTANCE_COUNT-1:0] cmpLevel;
	logic [UNIT_COUNT-1:0] unitEn;
	logic [UNIT_COUNT-1:0] unitPol;
	logic [7:0] unitDuty [UNIT_COUNT];
	logic [7:0] chanCount [CHANNEL_COUNT];
	logic [7:0] chanDuty [CHANNEL_COUNT];
	logic [CHANNEL_COUNT-1:0] chanActive;
	logic [CHANNEL_COUNT-1:0] chanShot;
	logic [CHANNEL_COUNT-1:0] drive;

	// One wait cycle per access, then the answer
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign wrEn = avs_write && ack;
	assign wData = avs_writedata[7:0];
	assign runWrite = wrEn && (avs_address == ADDR_TIMER_CTRL);

	always_ff @(posedge core_clk)
	begin
		if (srst)
			ack <= 1'b0;
		else
			ack <= (avs_read || avs_write) && !ack;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !ack)
			avs_readdata <= {24'h00_0000, readByte};
	end

	// Timer routing and base timer configuration
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			ccpAssign <= CCP_ASSIGN_RESET;
			pwmSelect <= PWM_SELECT_RESET;
			periodReg <= PERIOD_RESET;
			timerMode <= TIMER_MODE_RESET;
		end
		else if (wrEn)
		begin
			if (avs_address == ADDR_CCP_ASSIGN)
				ccpAssign <= wData;
			if (avs_address == ADDR_PWM_SELECT)
				pwmSelect <= wData;
			if (avs_address == ADDR_PERIOD)
				periodReg <= wData;
			if (avs_address == ADDR_TIMER_CTRL)
				timerMode <= wData[4:0];
		end
	end

	// External levels cross into the clock domain
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			trigSync1 <= 1'b0;
			trigSync2 <= 1'b0;
			capSync1 <= '0;
			capSync2 <= '0;
			capPrev <= '0;
		end
		else
		begin
			trigSync1 <= externalTrigger;
			trigSync2 <= trigSync1;
			capSync1 <= captureIn;
			capSync2 <= capSync1;
			capPrev <= capSync2;
		end
	end

	pwm_base_timer pwm_base_timer_inst (
		.core_clk(core_clk),
		.srst(srst),
		.timerMode(timerMode),
		.period(periodReg),
		.runWrite(runWrite),
		.runValue(wData[TIMER_RUN_BIT]),
		.trigger(trigSync2),
		.count(baseCount),
		.running(running),
		.oneShot(oneShot),
		.startPulse(startPulse)
	);

	for (genvar i = 0; i < INSTANCE_COUNT; i++)
	begin : gInst
		localparam logic [7:0] BASE = 8'(ADDR_INST_BASE + INST_STRIDE * i);
		logic [1:0] sel;
		logic [15:0] oddNow;
		logic level;

		assign sel = ccpAssign[2*i+:2];
		assign oddNow = oddCount(sel, timer1Count, timer3Count, timer5Count);

		always_ff @(posedge core_clk)
		begin
			if (srst)
			begin
				instMode[i] <= CCP_OFF;
				instOpenDrain[i] <= 1'b0;
			end
			else if (wrEn && avs_address == 8'(BASE + INST_CTRL_OFS))
			begin
				instMode[i] <= ccp_mode_type'(wData[1:0]);
				instOpenDrain[i] <= wData[INST_OD_BIT];
			end
		end

		// Captured count wins over a software write in the same cycle
		always_ff @(posedge core_clk)
		begin
			if (srst)
				instData[i] <= 16'h0000;
			else if (instMode[i] == CCP_CAPTURE && capSync2[i] && !capPrev[i])
				instData[i] <= oddNow;
			else if (wrEn && avs_address == 8'(BASE + INST_LOW_OFS))
				instData[i][7:0] <= wData;
			else if (wrEn && avs_address == 8'(BASE + INST_HIGH_OFS))
				instData[i][15:8] <= wData;
		end

		// Compare output is set on match and held while in compare mode
		always_ff @(posedge core_clk)
		begin
			if (srst || instMode[i] != CCP_COMPARE)
				cmpLevel[i] <= 1'b0;
			else if (oddNow == instData[i])
				cmpLevel[i] <= 1'b1;
		end

		assign level = (instMode[i] == CCP_PWM) ? drive[i] : cmpLevel[i];

		always_ff @(posedge core_clk)
		begin
			if (srst || instMode[i] == CCP_OFF || instMode[i] == CCP_CAPTURE)
			begin
				ccpPinOut[i] <= 1'b0;
				ccpPinOeN[i] <= 1'b1;
			end
			else if (instOpenDrain[i])
			begin
				ccpPinOut[i] <= 1'b0;
				ccpPinOeN[i] <= level;
			end
			else
			begin
				ccpPinOut[i] <= level;
				ccpPinOeN[i] <= 1'b0;
			end
		end

		assign chanCount[i] = evenCount(sel, baseCount, timer4Count, timer6Count);
		assign chanDuty[i] = instData[i][7:0];
		assign chanActive[i] = (instMode[i] == CCP_PWM);
		assign chanShot[i] = oneShot && onBaseTimer(sel);
	end

	for (genvar k = 0; k < UNIT_COUNT; k++)
	begin : gUnit
		localparam logic [7:0] BASE = 8'(ADDR_UNIT_BASE + UNIT_STRIDE * k);
		logic [1:0] sel;

		assign sel = pwmSelect[2*k+:2];

		always_ff @(posedge core_clk)
		begin
			if (srst)
			begin
				unitEn[k] <= 1'b0;
				unitPol[k] <= 1'b0;
				unitDuty[k] <= 8'h00;
			end
			else if (wrEn)
			begin
				if (avs_address == 8'(BASE + UNIT_CTRL_OFS))
				begin
					unitEn[k] <= wData[UNIT_EN_BIT];
					unitPol[k] <= wData[UNIT_POL_BIT];
				end
				if (avs_address == 8'(BASE + UNIT_DUTY_OFS))
					unitDuty[k] <= wData;
			end
		end

		// Polarity applied after the waveform
		always_ff @(posedge core_clk)
		begin
			if (srst)
				unitOut[k] <= 1'b0;
			else
				unitOut[k] <= drive[INSTANCE_COUNT+k] ^ unitPol[k];
		end

		assign chanCount[INSTANCE_COUNT+k] = evenCount(sel, baseCount, timer4Count,
			timer6Count);
		assign chanDuty[INSTANCE_COUNT+k] = unitDuty[k];
		assign chanActive[INSTANCE_COUNT+k] = unitEn[k];
		assign chanShot[INSTANCE_COUNT+k] = oneShot && onBaseTimer(sel);
	end

	// PWM waveform for every instance and unit
	for (genvar c = 0; c < CHANNEL_COUNT; c++)
	begin : gChan
		always_ff @(posedge core_clk)
		begin
			if (srst || !chanActive[c])
				drive[c] <= 1'b0;
			else if (chanShot[c])
			begin
				if (startPulse)
					drive[c] <= (chanDuty[c] != 8'h00);
				else if (chanCount[c] == chanDuty[c])
					drive[c] <= 1'b0;
			end
			else
				drive[c] <= (chanCount[c] < chanDuty[c]);
		end
	end

	// Read multiplexer; unmapped addresses read zero
	always_comb
	begin
		readByte = 8'h00;
		if (avs_address == ADDR_CCP_ASSIGN)
			readByte = ccpAssign;
		if (avs_address == ADDR_PWM_SELECT)
			readByte = pwmSelect;
		if (avs_address == ADDR_PERIOD)
			readByte = periodReg;
		if (avs_address == ADDR_TIMER_CTRL)
			readByte = {running, 2'b00, timerMode};
		if (avs_address == ADDR_TIMER_COUNT)
			readByte = baseCount;
		for (int i = 0; i < INSTANCE_COUNT; i++)
		begin
			if (avs_address == 8'(ADDR_INST_BASE + INST_STRIDE * i + INST_CTRL_OFS))
				readByte = {3'b000, instOpenDrain[i], 2'b00, instMode[i]};
			if (avs_address == 8'(ADDR_INST_BASE + INST_STRIDE * i + INST_LOW_OFS))
				readByte = instData[i][7:0];
			if (avs_address == 8'(ADDR_INST_BASE + INST_STRIDE * i + INST_HIGH_OFS))
				readByte = instData[i][15:8];
		end
		for (int k = 0; k < UNIT_COUNT; k++)
		begin
			if (avs_address == 8'(ADDR_UNIT_BASE + UNIT_STRIDE * k + UNIT_CTRL_OFS))
				readByte = {unitEn[k], 1'b0, unitOut[k], unitPol[k], 4'h0};
			if (avs_address == 8'(ADDR_UNIT_BASE + UNIT_STRIDE * k + UNIT_DUTY_OFS))
				readByte = unitDuty[k];
		end
	end
endmodule

// ==== verif/ccp_pwm_timer_select_properties.sv ====
// Concurrent checks on the register bus, pin drivers and unit outputs
`timescale 1ns/1ps
module ccp_pwm_timer_select_properties
	import ccp_pwm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Outputs
	input wire logic [ccp_pwm_pkg::INSTANCE_COUNT-1:0] ccpPinOut,
	input wire logic [ccp_pwm_pkg::INSTANCE_COUNT-1:0] ccpPinOeN,
	input wire logic [ccp_pwm_pkg::UNIT_COUNT-1:0] unitOut
);
	wire [7:0] unitOfs = avs_address - ADDR_UNIT_BASE;
	wire unitCtrl = unitOfs < 8'h20 && unitOfs[2:0] == 3'h0;
	wire taken = avs_read && !avs_waitrequest;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wait_one_a: assert property (
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	wait_idle_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("wait raised without a request");
	data_stands_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	upper_zero_a: assert property (taken |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	unit_zero_a: assert property (
		taken && unitCtrl |-> avs_readdata[6] == 1'b0 && avs_readdata[3:0] == 4'h0)
		else $error("unit control unused bits not zero");
	out_readback_a: assert property (
		taken && unitCtrl && $stable(unitOut) && $past(unitOut, 2) == unitOut
		|-> avs_readdata[5] == unitOut[unitOfs[4:3]])
		else $error("unit output readback differs from output");
	drain_only_a: assert property ((ccpPinOut & ccpPinOeN) == 4'h0)
		else $error("pin high while driver released");
	reset_quiet_a: assert property (
		disable iff (1'b0)
		srst |=> unitOut == 4'h0 && ccpPinOut == 4'h0 && ccpPinOeN == 4'hF)
		else $error("outputs active after reset");
	cover property (taken && unitCtrl);
	cover property ($rose(unitOut[0]));
	cover property ($fell(ccpPinOeN[0]));
endmodule
bind ccp_pwm_timer_select ccp_pwm_timer_select_properties props_inst (
	.core_clk(core_clk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ccpPinOut(ccpPinOut),
	.ccpPinOeN(ccpPinOeN), .unitOut(unitOut));

// ==== verif/timer_partner.sv ====
// On-chip timer counts and the external trigger level seen by the block
`timescale 1ns/1ps
module timer_partner #(
	parameter logic [15:0] T1_START = 16'h1234,
	parameter logic [15:0] T3_START = 16'h0300,
	parameter logic [7:0] T4_START = 8'h10,
	parameter logic [7:0] T6_START = 8'hF0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Bench control
	input wire logic run,
	input wire logic triggerLevel,
	// Timer counts and trigger pin
	output logic [15:0] timer1Count,
	output logic [15:0] timer3Count,
	output logic [15:0] timer5Count,
	output logic [7:0] timer4Count,
	output logic [7:0] timer6Count,
	output logic externalTrigger
);
	// Distinct start values make each timer source recognisable
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			timer1Count <= T1_START;
			timer3Count <= T3_START;
			timer5Count <= 16'h0500;
			timer4Count <= T4_START;
			timer6Count <= T6_START;
		end
		else if (run)
		begin
			timer1Count <= timer1Count + 16'h0001;
			timer3Count <= timer3Count + 16'h0001;
			timer5Count <= timer5Count + 16'h0001;
			timer4Count <= timer4Count + 8'h01;
			timer6Count <= timer6Count + 8'h01;
		end
	end
	assign externalTrigger = triggerLevel;
endmodule

// ==== verif/ccp_pwm_timer_select_bench.sv ====
// Self-checking bench for the capture/compare/PWM support block
`timescale 1ns/1ps
module ccp_pwm_timer_select_bench;
	import ccp_pwm_pkg::*;
	localparam logic [15:0] T1 = 16'h1234;
	localparam logic [15:0] T3 = 16'h0300;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic run = 1'b0;
	logic trig = 1'b0;
	logic [3:0] cap = 4'h0;
	logic [15:0] t1, t3, t5;
	logic [7:0] t4, t6;
	logic extTrig;
	logic [3:0] pinOut, pinOeN, unitOut;
	int failCount = 0;
	int comparisons = 0;
	int cycles = 0;
	ccp_pwm_timer_select ccp_pwm_timer_select_inst (.core_clk(core_clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .timer1Count(t1), .timer3Count(t3), .timer5Count(t5),
		.timer4Count(t4), .timer6Count(t6), .externalTrigger(extTrig), .captureIn(cap),
		.ccpPinOut(pinOut), .ccpPinOeN(pinOeN), .unitOut(unitOut));
	timer_partner #(.T1_START(T1), .T3_START(T3), .T4_START(8'h10), .T6_START(8'hF0))
		timer_partner_inst (.core_clk(core_clk), .srst(srst), .run(run), .triggerLevel(trig),
		.timer1Count(t1), .timer3Count(t3), .timer5Count(t5), .timer4Count(t4),
		.timer6Count(t6), .externalTrigger(extTrig));
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failCount++;
			finishTest();
		end
	end
	task automatic finishTest();
		$display("comparisons %0d, mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			failCount++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk($sformatf("register %h", a), e, q);
	endtask
	// Waits up to lim cycles for a unit output level, then compares it
	task automatic waitOut(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (unitOut[k] !== v && n < lim)
		begin
			@(posedge core_clk);
			n++;
		end
		chk($sformatf("unitOut %0d", k), {31'h0, v}, {31'h0, unitOut[k]});
	endtask
	task automatic resetValues();
		rd(ADDR_CCP_ASSIGN, 32'h00);
		rd(ADDR_PWM_SELECT, 32'h55);
		for (int k = 0; k < UNIT_COUNT; k++)
			rd(8'(ADDR_UNIT_BASE + UNIT_STRIDE * k), 32'h00);
		rd(ADDR_PERIOD, 32'hFF);
	endtask
	task automatic unitControl();
		wr(ADDR_UNIT_BASE, 8'hFF);
		repeat (4) @(posedge core_clk);
		waitOut(0, 1'b1, 0);
		rd(ADDR_UNIT_BASE, 32'hB0);
		wr(ADDR_UNIT_BASE, 8'hA0);
		repeat (4) @(posedge core_clk);
		rd(ADDR_UNIT_BASE, 32'h80);
		wr(ADDR_UNIT_BASE, 8'h00);
		rd(ADDR_UNIT_BASE, 32'h00);
	endtask
	task automatic timerSelect();
		logic [3:0] levels;
		levels = 4'b1011;
		wr(ADDR_UNIT_BASE + UNIT_STRIDE + UNIT_DUTY_OFS, 8'h80);
		wr(ADDR_UNIT_BASE + UNIT_STRIDE, 8'h80);
		for (int c = 0; c < 4; c++)
		begin
			wr(ADDR_PWM_SELECT, 8'(c << 2));
			repeat (4) @(posedge core_clk);
			waitOut(1, levels[c], 0);
		end
		wr(ADDR_UNIT_BASE + UNIT_STRIDE, 8'h00);
	endtask
	task automatic ccpInstances();
		logic [15:0] d;
		wr(ADDR_CCP_ASSIGN, 8'h10);
		for (int i = 0; i < INSTANCE_COUNT; i++)
		begin
			d = (i < 2 ? T1 : T3) + 16'h0100;
			wr(8'(ADDR_INST_BASE + INST_STRIDE * i + INST_LOW_OFS), d[7:0]);
			wr(8'(ADDR_INST_BASE + INST_STRIDE * i + INST_HIGH_OFS), d[15:8]);
			wr(8'(ADDR_INST_BASE + INST_STRIDE * i), i == 1 ? 8'h12 : 8'h02);
		end
		rd(ADDR_INST_BASE + INST_LOW_OFS, 32'h34);
		rd(ADDR_INST_BASE + INST_HIGH_OFS, 32'h13);
		rd(ADDR_CCP_ASSIGN, 32'h10);
		run <= 1'b1;
		repeat (300) @(posedge core_clk);
		chk("ccpPinOut", 32'h5, {28'h0, pinOut});
		chk("ccpPinOeN", 32'h2, {28'h0, pinOeN});
		// Instance 1 to push-pull PWM on the idle base timer, instance 3 to capture
		wr(ADDR_INST_BASE + INST_STRIDE, 8'h03);
		wr(8'(ADDR_INST_BASE + INST_STRIDE * 3), 8'h01);
		cap <= 4'h8;
		repeat (3) @(posedge core_clk);
		d = t1;
		chk("ccpPinOut", 32'h7, {28'h0, pinOut});
		chk("ccpPinOeN", 32'h8, {28'h0, pinOeN});
		rd(8'(ADDR_INST_BASE + INST_STRIDE * 3 + INST_LOW_OFS), {24'h0, d[7:0]});
		rd(8'(ADDR_INST_BASE + INST_STRIDE * 3 + INST_HIGH_OFS), {24'h0, d[15:8]});
	endtask
	task automatic oneShot();
		wr(ADDR_PWM_SELECT, 8'h00);
		wr(ADDR_PERIOD, 8'h05);
		wr(ADDR_UNIT_BASE + UNIT_DUTY_OFS, 8'h03);
		wr(ADDR_TIMER_CTRL, 8'h8E);
		wr(ADDR_UNIT_BASE, 8'h80);
		repeat (8) @(posedge core_clk);
		rd(ADDR_TIMER_COUNT, 32'h00);
		waitOut(0, 1'b0, 0);
		trig <= 1'b1;
		waitOut(0, 1'b1, 20);
		waitOut(0, 1'b0, 20);
		repeat (10) @(posedge core_clk);
		rd(ADDR_TIMER_CTRL, 32'h0E);
		rd(ADDR_TIMER_COUNT, 32'h00);
		waitOut(0, 1'b0, 0);
		trig <= 1'b0;
		repeat (5) @(posedge core_clk);
		trig <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(ADDR_TIMER_COUNT, 32'h00);
		wr(ADDR_TIMER_CTRL, 8'h8E);
		repeat (10) @(posedge core_clk);
		rd(ADDR_TIMER_COUNT, 32'h00);
		rd(ADDR_TIMER_CTRL, 32'h8E);
		wr(ADDR_TIMER_CTRL, 8'h8F);
		repeat (8) @(posedge core_clk);
		rd(ADDR_TIMER_COUNT, 32'h00);
		trig <= 1'b0;
		waitOut(0, 1'b1, 20);
		waitOut(0, 1'b0, 20);
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		resetValues();
		unitControl();
		timerSelect();
		ccpInstances();
		oneShot();
		wr(8'hFC, 8'hAA);
		rd(8'hFC, 32'h00);
		finishTest();
	end
endmodule
